// file: src/cjm_decoder.sv
// Decode and execute core for in-page jumps, control and data moves.
// Assumes program memory returns the byte at prog_addr in the same cycle.
`default_nettype none
// Operation
// (RULE1) Opcode 56 jumps in page if test_pin_b high
// (RULE2) Opcode C6 jumps in page if accumulator zero
// (RULE3) Opcode 05 enables external interrupt
// (RULE4) Opcode 15 disables external interrupt
// (RULE5) Opcode 75 drives clock onto test_pin_a
// (RULE6) Opcode E5 clears program bank flop
// (RULE7) Opcode F5 sets program bank flop
// (RULE8) Opcode C5 clears register bank bit
// (RULE9) Opcode D5 sets register bank bit
// (RULE10) Opcode 01 enters halt mode
// (RULE11) Opcode 23 loads immediate into accumulator
// (RULE12) 11111rrr copies working register to accumulator
// (RULE13) 1111000r loads accumulator from indirect memory
// (RULE14) Opcode C7 copies status word to accumulator
// (RULE15) 10111rrr writes immediate into working register
// (RULE16) 10101rrr copies accumulator to working register
// (RULE17) 1010000r stores accumulator to indirect memory
// (RULE18) 1011000r writes immediate to indirect memory
// (RULE19) Opcode D7 loads status word from accumulator
// (RULE20) Long jump takes bit 11 from bank flop
// (RULE21) Opcode fetched first, operand from next location
module cjm_decoder
  import cjm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] prog_data,
  input wire logic test_pin_b,
  input wire logic ext_irq_n,
  output logic [PC_W-1:0] prog_addr,
  output logic [7:0] acc_reg,
  output logic [7:0] status_word_reg,
  output logic ext_irq_on_reg,
  output logic irq_request_reg,
  output logic prog_bank_flop_reg,
  output logic halted_reg,
  output logic test_pin_a_out_reg,
  output logic test_pin_a_oe_reg
);

  cjm_state_type state_reg;
  logic [PC_W-1:0] pc_reg;
  logic [7:0] op_reg;
  logic [7:0] dmem [DMEM_DEPTH];
  logic clock_out_on_reg;
  logic tb_s1, tb_s2, tb_s3, tb_level;
  logic ir_s1, ir_s2, ir_s3, ir_level;
  logic [7:0] cur_op;
  logic exec_one, exec_two;

  function automatic logic two_byte(input logic [7:0] op);
    two_byte = (op == OP_JTB) || (op == OP_JZ) || (op == OP_ACC_IMM) ||
      (op[7:3] == PAT_WR_IMM) || (op[7:1] == PAT_IND_IMM) ||
      (op[4:0] == PAT_LJMP);
  endfunction

  function automatic logic [5:0] wr_addr(input logic bank,
                                         input logic [2:0] r);
    wr_addr = bank ? (RBANK1_BASE | {3'h0, r}) : {3'h0, r};
  endfunction

  assign prog_addr = pc_reg;
  assign cur_op = (state_reg == ST_OP) ? prog_data : op_reg;
  assign exec_one = (state_reg == ST_OP) && !two_byte(prog_data);
  assign exec_two = (state_reg == ST_ARG);

  logic bank;
  logic [5:0] ind_addr;
  logic [5:0] reg_addr;
  assign bank = status_word_reg[RBANK_BIT];
  assign reg_addr = wr_addr(bank, cur_op[2:0]);
  assign ind_addr = dmem[wr_addr(bank, {2'h0, cur_op[0]})][5:0];

  // Pin synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tb_s1 <= 1'b0;
      tb_s2 <= 1'b0;
      tb_s3 <= 1'b0;
      tb_level <= 1'b0;
      ir_s1 <= 1'b1;
      ir_s2 <= 1'b1;
      ir_s3 <= 1'b1;
      ir_level <= 1'b1;
    end else begin
      tb_s1 <= test_pin_b;
      tb_s2 <= tb_s1;
      tb_s3 <= tb_s2;
      if (tb_s2 == tb_s3) begin
        tb_level <= tb_s3;
      end
      ir_s1 <= ext_irq_n;
      ir_s2 <= ir_s1;
      ir_s3 <= ir_s2;
      if (ir_s2 == ir_s3) begin
        ir_level <= ir_s3;
      end
    end
  end

  // Sequencer and program counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_OP;
      pc_reg <= PC_RST;
      op_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_OP: begin
          op_reg <= prog_data;
          pc_reg <= pc_reg + 12'h001;
          if (two_byte(prog_data)) begin
            state_reg <= ST_ARG; // [RULE21]
          end else if (prog_data == OP_HALT) begin
            state_reg <= ST_HALT; // [RULE10]
          end
        end
        ST_ARG: begin
          state_reg <= ST_OP;
          if (op_reg == OP_JTB && tb_level) begin
            pc_reg[7:0] <= prog_data; // [RULE1]
          end else if (op_reg == OP_JZ && acc_reg == 8'h00) begin
            pc_reg[7:0] <= prog_data; // [RULE2]
          end else if (op_reg[4:0] == PAT_LJMP) begin
            pc_reg <= {prog_bank_flop_reg, op_reg[7:5], prog_data}; // [RULE20]
          end else begin
            pc_reg <= pc_reg + 12'h001; // [RULE1] [RULE2]
          end
        end
        ST_HALT: begin
          state_reg <= ST_HALT;
        end
        default: begin
          state_reg <= ST_OP;
        end
      endcase
    end
  end

  // Accumulator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= ACC_RST;
    end else if (exec_one) begin
      if (cur_op[7:3] == PAT_ACC_WR) begin
        acc_reg <= dmem[reg_addr]; // [RULE12]
      end else if (cur_op[7:1] == PAT_ACC_IND) begin
        acc_reg <= dmem[ind_addr]; // [RULE13]
      end else if (cur_op == OP_ACC_SW) begin
        acc_reg <= status_word_reg; // [RULE14]
      end
    end else if (exec_two && cur_op == OP_ACC_IMM) begin
      acc_reg <= prog_data; // [RULE11]
    end
  end

  // Status word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_word_reg <= SW_RST;
    end else if (exec_one) begin
      if (cur_op == OP_RBANK_LO) begin
        status_word_reg[RBANK_BIT] <= 1'b0; // [RULE8]
      end else if (cur_op == OP_RBANK_HI) begin
        status_word_reg[RBANK_BIT] <= 1'b1; // [RULE9]
      end else if (cur_op == OP_SW_ACC) begin
        status_word_reg <= acc_reg; // [RULE19]
      end
    end
  end

  // Data memory and working registers
  always_ff @(posedge clk) begin
    if (!rst && exec_one) begin
      if (cur_op[7:3] == PAT_WR_ACC) begin
        dmem[reg_addr] <= acc_reg; // [RULE16]
      end else if (cur_op[7:1] == PAT_IND_ACC) begin
        dmem[ind_addr] <= acc_reg; // [RULE17]
      end
    end else if (!rst && exec_two) begin
      if (cur_op[7:3] == PAT_WR_IMM) begin
        dmem[reg_addr] <= prog_data; // [RULE15]
      end else if (cur_op[7:1] == PAT_IND_IMM) begin
        dmem[ind_addr] <= prog_data; // [RULE18]
      end
    end
  end

  // Control flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_irq_on_reg <= 1'b0;
      clock_out_on_reg <= 1'b0;
      prog_bank_flop_reg <= 1'b0;
      halted_reg <= 1'b0;
    end else begin
      if (exec_one && cur_op == OP_IRQ_ON) begin
        ext_irq_on_reg <= 1'b1; // [RULE3]
      end else if (exec_one && cur_op == OP_IRQ_OFF) begin
        ext_irq_on_reg <= 1'b0; // [RULE4]
      end
      if (exec_one && cur_op == OP_CLKO_ON) begin
        clock_out_on_reg <= 1'b1; // [RULE5]
      end
      if (exec_one && cur_op == OP_PBANK_LO) begin
        prog_bank_flop_reg <= 1'b0; // [RULE6]
      end else if (exec_one && cur_op == OP_PBANK_HI) begin
        prog_bank_flop_reg <= 1'b1; // [RULE7]
      end
      if (exec_one && cur_op == OP_HALT) begin
        halted_reg <= 1'b1; // [RULE10]
      end
    end
  end

  // Interrupt request and clock out pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_request_reg <= 1'b0;
      test_pin_a_out_reg <= 1'b0;
      test_pin_a_oe_reg <= 1'b0;
    end else begin
      irq_request_reg <= ext_irq_on_reg && !ir_level; // [RULE3] [RULE4]
      test_pin_a_oe_reg <= clock_out_on_reg; // [RULE5]
      test_pin_a_out_reg <= clock_out_on_reg && !test_pin_a_out_reg;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_jtb_taken: assert property ( // [RULE1]
    state_reg == ST_ARG && op_reg == OP_JTB && tb_level
    |=> pc_reg[7:0] == $past(prog_data) &&
        pc_reg[11:8] == $past(pc_reg[11:8]))
    else $error("in-page jump on test pin b not taken");
  a_jz_skip: assert property ( // [RULE2]
    state_reg == ST_ARG && op_reg == OP_JZ && acc_reg != 8'h00
    |=> pc_reg == $past(pc_reg) + 12'h001)
    else $error("zero jump did not skip");
  a_irq_gate: assert property ( // [RULE3]
    ext_irq_on_reg && !ir_level |=> irq_request_reg)
    else $error("enabled interrupt not requested");
  a_irq_off: assert property ( // [RULE4]
    state_reg == ST_OP && prog_data == OP_IRQ_OFF
    |=> !ext_irq_on_reg ##1 !irq_request_reg)
    else $error("interrupt still active after disable");
  a_clk_out: assert property ( // [RULE5]
    state_reg == ST_OP && prog_data == OP_CLKO_ON
    |=> ##1 test_pin_a_oe_reg)
    else $error("clock out not driven");
  a_bank_ljmp: assert property ( // [RULE20]
    state_reg == ST_ARG && op_reg[4:0] == PAT_LJMP
    |=> pc_reg[11] == $past(prog_bank_flop_reg))
    else $error("long jump bank bit wrong");
  a_pbank_set: assert property ( // [RULE7]
    state_reg == ST_OP && prog_data == OP_PBANK_HI
    |=> prog_bank_flop_reg && pc_reg == $past(pc_reg) + 12'h001)
    else $error("program bank flop not set");
  a_rbank_hi: assert property ( // [RULE9]
    state_reg == ST_OP && prog_data == OP_RBANK_HI
    |=> status_word_reg[RBANK_BIT])
    else $error("register bank bit not set");
  a_halt_stays: assert property ( // [RULE10]
    state_reg == ST_OP && prog_data == OP_HALT
    |=> (halted_reg && state_reg == ST_HALT) [*3])
    else $error("halt mode not held");
  a_acc_imm: assert property ( // [RULE11]
    state_reg == ST_OP && prog_data == OP_ACC_IMM
    |=> state_reg == ST_ARG ##1 acc_reg == $past(prog_data))
    else $error("immediate not loaded");
  a_sw_acc: assert property ( // [RULE19]
    state_reg == ST_OP && prog_data == OP_SW_ACC
    |=> status_word_reg == $past(acc_reg))
    else $error("status word not loaded");
  a_jtb_skip: assert property ( // [RULE1]
    state_reg == ST_ARG && op_reg == OP_JTB && !tb_level
    |=> pc_reg == $past(pc_reg) + 12'h001)
    else $error("in-page jump on test pin b not skipped");
  a_pbank_clr: assert property ( // [RULE6]
    state_reg == ST_OP && prog_data == OP_PBANK_LO
    |=> !prog_bank_flop_reg && pc_reg == $past(pc_reg) + 12'h001)
    else $error("program bank flop not cleared");
  a_rbank_lo: assert property ( // [RULE8]
    state_reg == ST_OP && prog_data == OP_RBANK_LO
    |=> !status_word_reg[RBANK_BIT])
    else $error("register bank bit not cleared");
  a_acc_wreg: assert property ( // [RULE12]
    state_reg == ST_OP && prog_data[7:3] == PAT_ACC_WR
    |=> acc_reg == $past(dmem[reg_addr]))
    else $error("working register not copied to accumulator");
  a_acc_ind: assert property ( // [RULE13]
    state_reg == ST_OP && prog_data[7:1] == PAT_ACC_IND
    |=> acc_reg == $past(dmem[ind_addr]))
    else $error("indirect load to accumulator wrong");
  a_acc_sw: assert property ( // [RULE14]
    state_reg == ST_OP && prog_data == OP_ACC_SW
    |=> acc_reg == $past(status_word_reg))
    else $error("status word not copied to accumulator");
  a_wreg_imm: assert property ( // [RULE15]
    state_reg == ST_ARG && op_reg[7:3] == PAT_WR_IMM
    |=> dmem[$past(reg_addr)] == $past(prog_data))
    else $error("immediate not written to working register");
  a_wreg_acc: assert property ( // [RULE16]
    state_reg == ST_OP && prog_data[7:3] == PAT_WR_ACC
    |=> dmem[$past(reg_addr)] == $past(acc_reg))
    else $error("accumulator not copied to working register");
  a_ind_acc: assert property ( // [RULE17]
    state_reg == ST_OP && prog_data[7:1] == PAT_IND_ACC
    |=> dmem[$past(ind_addr)] == $past(acc_reg))
    else $error("indirect store of accumulator wrong");
  a_ind_imm: assert property ( // [RULE18]
    state_reg == ST_ARG && op_reg[7:1] == PAT_IND_IMM
    |=> dmem[$past(ind_addr)] == $past(prog_data))
    else $error("indirect store of immediate wrong");
  a_arg_fetch: assert property ( // [RULE21]
    state_reg == ST_OP && two_byte(prog_data)
    |=> state_reg == ST_ARG && prog_addr == $past(prog_addr) + 12'h001)
    else $error("operand not fetched from next location");

endmodule
`default_nettype wire

// file: common/cjm_pkg.sv
// Constants and types for the jump, control and move decoder.
// Assumes a single 100 MHz core clock and one byte of program memory per cycle.
`default_nettype none
package cjm_pkg;
  localparam int PC_W = 12;
  localparam int DMEM_DEPTH = 64;
  localparam logic [7:0] OP_JTB = 8'h56;
  localparam logic [7:0] OP_JZ = 8'hC6;
  localparam logic [7:0] OP_IRQ_ON = 8'h05;
  localparam logic [7:0] OP_IRQ_OFF = 8'h15;
  localparam logic [7:0] OP_CLKO_ON = 8'h75;
  localparam logic [7:0] OP_PBANK_LO = 8'hE5;
  localparam logic [7:0] OP_PBANK_HI = 8'hF5;
  localparam logic [7:0] OP_RBANK_LO = 8'hC5;
  localparam logic [7:0] OP_RBANK_HI = 8'hD5;
  localparam logic [7:0] OP_HALT = 8'h01;
  localparam logic [7:0] OP_ACC_IMM = 8'h23;
  localparam logic [7:0] OP_ACC_SW = 8'hC7;
  localparam logic [7:0] OP_SW_ACC = 8'hD7;
  localparam logic [4:0] PAT_ACC_WR = 5'h1F;
  localparam logic [6:0] PAT_ACC_IND = 7'h78;
  localparam logic [4:0] PAT_WR_IMM = 5'h17;
  localparam logic [4:0] PAT_WR_ACC = 5'h15;
  localparam logic [6:0] PAT_IND_ACC = 7'h50;
  localparam logic [6:0] PAT_IND_IMM = 7'h58;
  localparam logic [4:0] PAT_LJMP = 5'h04;
  localparam int RBANK_BIT = 4;
  localparam logic [5:0] RBANK1_BASE = 6'h18;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] SW_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 12'h000;
  typedef enum {ST_OP, ST_ARG, ST_HALT} cjm_state_type;
endpackage
`default_nettype wire

// file: sim/cjm_prog_mem.sv
// Program memory model facing the decoder fetch port.
// Assumes the bench loads bytes before reset is released.
`default_nettype none
module cjm_prog_mem
  import cjm_pkg::*;
(
  input wire logic [PC_W-1:0] addr,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rom [0:4095];
  // Same-cycle byte at the current address
  assign data = rom[addr];
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench running one program through the decoder.
// Assumes the memory model answers combinationally.
`default_nettype none
module testbench
  import cjm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, test_pin_b, ext_irq_n, o;
  logic [7:0] prog_data, acc_reg, status_word_reg;
  logic [PC_W-1:0] prog_addr, h;
  logic ext_irq_on_reg, irq_request_reg, prog_bank_flop_reg, halted_reg;
  logic test_pin_a_out_reg, test_pin_a_oe_reg;
  int err_count = 0;
  int comparisons = 0;
  cjm_decoder cjm_decoder_i(.clk(clk), .rst(rst), .prog_data(prog_data),
    .test_pin_b(test_pin_b), .ext_irq_n(ext_irq_n), .prog_addr(prog_addr),
    .acc_reg(acc_reg), .status_word_reg(status_word_reg),
    .ext_irq_on_reg(ext_irq_on_reg), .irq_request_reg(irq_request_reg),
    .prog_bank_flop_reg(prog_bank_flop_reg), .halted_reg(halted_reg),
    .test_pin_a_out_reg(test_pin_a_out_reg),
    .test_pin_a_oe_reg(test_pin_a_oe_reg));
  cjm_prog_mem cjm_prog_mem_i(.addr(prog_addr), .data(prog_data));
  task automatic seg(input int a, input int n, input logic [127:0] v);
    for (int i = 0; i < n; i++) begin
      cjm_prog_mem_i.rom[a + i] = v[8 * (n - 1 - i) +: 8];
    end
  endtask
  task automatic chk(input string n, input logic [11:0] x,
                     input logic [11:0] g);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wait_pc(input logic [11:0] a);
    int n;
    n = 0;
    @(negedge clk);
    while (prog_addr !== a && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("prog_addr", a, prog_addr);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    results();
  end
  initial begin
    rst = 1'b1;
    test_pin_b = 1'b1;
    ext_irq_n = 1'b0;
    seg(12'h000, 4, 128'h2300C610);
    seg(12'h010, 4, 128'h235AC640);
    seg(12'h014, 12, 128'hB820B0ABF0AB233CA02300F0);
    seg(12'h020, 15, 128'hFBD5BB99C5FBB81BF023A5D72300C7);
    seg(12'h02F, 8, 128'h0556301575F50400);
    seg(12'h800, 5, 128'hE52300C608);
    seg(12'h808, 2, 128'h0440);
    seg(12'h040, 1, 128'h01);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wait_pc(12'h010);
    wait_pc(12'h014);
    wait_pc(12'h019);
    chk("acc", 12'h0AB, {4'h0, acc_reg});
    wait_pc(12'h020);
    chk("acc", 12'h03C, {4'h0, acc_reg});
    wait_pc(12'h021);
    chk("acc", 12'h0AB, {4'h0, acc_reg});
    wait_pc(12'h022);
    chk("bank", 12'h001, {11'h0, status_word_reg[4]});
    wait_pc(12'h025);
    chk("bank", 12'h000, {11'h0, status_word_reg[4]});
    wait_pc(12'h026);
    chk("acc", 12'h0AB, {4'h0, acc_reg});
    wait_pc(12'h029);
    chk("acc", 12'h099, {4'h0, acc_reg});
    wait_pc(12'h02C);
    chk("status", 12'h0A5, {4'h0, status_word_reg});
    wait_pc(12'h02F);
    chk("acc", 12'h0A5, {4'h0, acc_reg});
    $display("moves test done");
    wait_pc(12'h030);
    chk("irq_on", 12'h001, {11'h0, ext_irq_on_reg});
    repeat (8) @(negedge clk);
    chk("irq_req", 12'h001, {11'h0, irq_request_reg});
    chk("spin", 12'h030, {prog_addr[11:1], 1'b0});
    @(posedge clk);
    test_pin_b <= 1'b0;
    wait_pc(12'h032);
    wait_pc(12'h033);
    chk("irq_on", 12'h000, {11'h0, ext_irq_on_reg});
    wait_pc(12'h034);
    chk("irq_req", 12'h000, {11'h0, irq_request_reg});
    wait_pc(12'h035);
    chk("flop", 12'h001, {11'h0, prog_bank_flop_reg});
    wait_pc(12'h036);
    chk("oe", 12'h001, {11'h0, test_pin_a_oe_reg});
    wait_pc(12'h800);
    o = test_pin_a_out_reg;
    wait_pc(12'h801);
    chk("clk_out", {11'h0, ~o}, {11'h0, test_pin_a_out_reg});
    chk("flop", 12'h000, {11'h0, prog_bank_flop_reg});
    wait_pc(12'h808);
    wait_pc(12'h040);
    $display("control test done");
    repeat (4) @(negedge clk);
    chk("halted", 12'h001, {11'h0, halted_reg});
    h = prog_addr;
    repeat (5) @(negedge clk);
    chk("prog_addr", h, prog_addr);
    $display("halt test done");
    results();
  end
endmodule
`default_nettype wire
